/* hw/rst_seq_cfg.svh */
// Offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH
`define CLK_HZ              20000000
// Wishbone word offsets (byte addresses)
`define OFS_FILTER_CTRL     8'h00
`define OFS_MODE_CTRL       8'h04
`define OFS_STATUS          8'h08
`define OFS_CAUSE           8'h0C
// Filter control fields
`define FLD_SAMPLE_SEL      0
`define FLD_FILTER_TYPE     1
`define FILTER_CTRL_RST     8'h00
// Mode control fields
`define FLD_WD1_EN          0
`define FLD_WD2_EN          1
`define MODE_CTRL_RST       8'h03
// Sample counts
`define SAMPLES_LONG        20
`define SAMPLES_SHORT       10
// Watchdog one hold, in system clock cycles
`define WD1_HOLD_CYCLES     12
// Analog delay after watchdog two, in ns
`define WD2_DELAY_NS        1000
`define WD2_DELAY_CYCLES    ((`WD2_DELAY_NS * (`CLK_HZ / 1000000) + 999) / 1000)
// Default stabilisation wait, in cycles of the main clock
`define STAB_CYCLES_DEFAULT 65536
`endif

/* hw/rst_seq_pkg.sv */
// Types shared by the reset sequencer
`default_nettype none
package rst_seq_pkg;
   typedef enum logic [2:0] {
      ST_RUN,
      ST_HOLD_WD1,
      ST_HOLD_WD2,
      ST_HOLD_EXT,
      ST_STAB
   } seq_state_e;
   typedef enum logic [1:0] {
      CLK_OFF,
      CLK_DIV8,
      CLK_RUN
   } clk_mode_e;
endpackage : rst_seq_pkg
`default_nettype wire

/* hw/reset_pin_filter.sv */
// Digital pulse-width filter for the external reset pin
`include "rst_seq_cfg.svh"
`default_nettype none
module reset_pin_filter (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sample_en,
   input  wire logic pin_low,
   input  wire logic short_count,
   output logic      detected
);
   logic [4:0] count;
   logic [4:0] next_count;
   logic       next_detected;
   logic [4:0] limit;

   always_comb begin
      limit = short_count ? 5'(`SAMPLES_SHORT) : 5'(`SAMPLES_LONG);
      next_count = count;
      next_detected = detected;
      if (!pin_low) begin
         next_count = 5'h00;
         next_detected = 1'b0;
      end else if (sample_en) begin
         // Counting from the first low sample: N samples low means N periods
         if (count < limit) begin
            next_count = count + 5'h01;
         end
         if (count + 5'h01 >= limit) begin
            next_detected = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 5'h00;
         detected <= 1'b0;
      end else begin
         count <= next_count;
         detected <= next_detected;
      end
   end
endmodule : reset_pin_filter
`default_nettype wire

/* hw/reset_source_sequencer.sv */
// Reset sequencer: pin filter, watchdog and power-on-clear resets, clock and port states
`include "rst_seq_cfg.svh"
`default_nettype none
// Functional notes
// - Pin low for N sample periods is always taken as a reset.
// - Pulses between N-1 and N periods may go either way; shorter ones are dropped. Code drops them only while filter type 1 is digitally active.
// - Watchdog one overflow resets the system when that mode is enabled and the sequencer is in run or a watchdog one hold.
// - Watchdog one reset holds exactly 12 system clock cycles, then releases.
// - Watchdog one reset keeps the oscillator, so no stabilisation wait.
// - Watchdog one reset keeps clocks running, system clock to div8, peripherals stop.
// - During any reset the reset-out line drives low, other ports float.
// - Watchdog two stays stopped in reset and starts on internal clock after.
// - RAM is kept over reset unless a write coincides with it.
// - Watchdog two overflow resets the system when that mode is enabled.
// - Watchdog two reset holds for the analog delay, then releases alone.
// - Watchdog two and power-on-clear resets wait the default stabilisation time.
// - Watchdog two reset leaves hardware in the same state as a pin reset.
// - Power-on-clear holds reset while supply is low, then stabilisation wait.
// - Power-on-clear stops main and internal oscillators; subclock keeps running.
// - After power-on-clear, clocks start at div8 after wait; watchdog one clock at once.
// - Filter samples on the main clock; select 0 gives 20 samples, 1 gives 10.
// - Filter type 1 is digital plus analog; analog only while sampling clock stops.
// - Filter control takes only the first write after reset release.
module reset_source_sequencer #(
   parameter int STAB_CYCLES = `STAB_CYCLES_DEFAULT
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        reset_pin_n,
   input  wire logic        watchdog_one_overflow,
   input  wire logic        watchdog_two_overflow,
   input  wire logic        supply_below_threshold,
   input  wire logic        sample_clock_stopped,
   input  wire logic        cpu_ram_write,
   output logic             system_reset,
   output logic             cpu_run,
   output logic             main_osc_enable,
   output logic             internal_osc_enable,
   output logic             subclock_enable,
   output logic             peripheral_clock_enable,
   output logic             system_clock_enable,
   output logic             system_clock_div8,
   output logic             watchdog_one_clock_enable,
   output logic             watchdog_two_run,
   output logic             reset_out_port_line_o,
   output logic             reset_out_port_line_oe,
   output logic             ports_release,
   output logic             ram_write_corrupt
);
   localparam int WD2_CYCLES = `WD2_DELAY_CYCLES;

   // Pin, supply, sampling-stop and watchdog synchronisers
   logic [1:0] pin_sync;
   logic [1:0] pwr_sync;
   logic [1:0] stop_sync;
   logic [1:0] wd1_sync;
   logic [1:0] wd2_sync;
   logic       wd1_prev;
   logic       wd2_prev;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync <= 2'h3;
         pwr_sync <= 2'h3;
         stop_sync <= 2'h0;
         wd1_sync <= 2'h0;
         wd2_sync <= 2'h0;
         wd1_prev <= 1'b0;
         wd2_prev <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[0], reset_pin_n};
         pwr_sync <= {pwr_sync[0], supply_below_threshold};
         stop_sync <= {stop_sync[0], sample_clock_stopped};
         wd1_sync <= {wd1_sync[0], watchdog_one_overflow};
         wd2_sync <= {wd2_sync[0], watchdog_two_overflow};
         wd1_prev <= wd1_sync[1];
         wd2_prev <= wd2_sync[1];
      end
   end

   logic wd1_event;
   logic wd2_event;
   logic pwr_low;
   assign wd1_event = wd1_sync[1] & ~wd1_prev;
   assign wd2_event = wd2_sync[1] & ~wd2_prev;
   assign pwr_low = pwr_sync[1];

   // Registers
   logic [1:0] filter_ctrl;
   logic       filter_locked;
   logic [1:0] mode_ctrl;
   logic [2:0] cause;
   logic [1:0] next_filter_ctrl;
   logic       next_filter_locked;
   logic [1:0] next_mode_ctrl;
   logic [2:0] next_cause;
   logic [31:0] next_wb_dat;
   logic        next_wb_ack;
   logic        wb_req;
   logic        wb_wr;

   logic pin_reset;
   rst_seq_pkg::seq_state_e state;
   rst_seq_pkg::seq_state_e next_state;

   // Filter: samples every cycle; digital result used only while the main clock runs, which is stopped in long resets
   logic digital_active;
   logic filt_detected;
   logic main_running;
   assign digital_active = filter_ctrl[`FLD_FILTER_TYPE] & ~stop_sync[1] & main_running;

   reset_pin_filter u_filter (
      .clk         (clk),
      .rst_n       (rst_n),
      .sample_en   (1'b1),
      .pin_low     (~pin_sync[1]),
      .short_count (filter_ctrl[`FLD_SAMPLE_SEL]),
      .detected    (filt_detected)
   );
   // Analog only: any synchronised low is a reset
   assign pin_reset = digital_active ? filt_detected : ~pin_sync[1];

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

   always_comb begin
      next_filter_ctrl = filter_ctrl;
      next_filter_locked = filter_locked;
      next_mode_ctrl = mode_ctrl;
      next_cause = cause;
      next_wb_ack = wb_req;
      next_wb_dat = 32'h0000_0000;
      if (wb_wr && wb_adr_i == `OFS_FILTER_CTRL && !filter_locked) begin
         next_filter_ctrl = wb_dat_i[1:0];
         next_filter_locked = 1'b1;
      end
      if (wb_wr && wb_adr_i == `OFS_MODE_CTRL) begin
         next_mode_ctrl = wb_dat_i[1:0];
      end
      if (wb_wr && wb_adr_i == `OFS_CAUSE) begin
         next_cause = cause & ~wb_dat_i[2:0];
      end
      // Set wins over a clear in the same cycle
      if (pin_reset) next_cause[0] = 1'b1;
      if (wd1_event && mode_ctrl[`FLD_WD1_EN]) next_cause[1] = 1'b1;
      if ((wd2_event && mode_ctrl[`FLD_WD2_EN]) || pwr_low) next_cause[2] = 1'b1;
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            `OFS_FILTER_CTRL: next_wb_dat = {29'h0, filter_locked, filter_ctrl};
            `OFS_MODE_CTRL:   next_wb_dat = {30'h0, mode_ctrl};
            `OFS_STATUS:      next_wb_dat = {27'h0, pwr_low, ~pin_sync[1], state};
            `OFS_CAUSE:       next_wb_dat = {29'h0, cause};
            default:          next_wb_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filter_ctrl <= 2'(`FILTER_CTRL_RST);
         filter_locked <= 1'b0;
         mode_ctrl <= 2'(`MODE_CTRL_RST);
         cause <= 3'h0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         filter_ctrl <= next_filter_ctrl;
         filter_locked <= next_filter_locked;
         mode_ctrl <= next_mode_ctrl;
         cause <= next_cause;
         wb_ack_o <= next_wb_ack;
         wb_dat_o <= next_wb_dat;
      end
   end

   // Sequencer
   logic [16:0] count;
   logic [16:0] next_count;
   logic        soft_reset;
   logic        next_soft_reset;
   logic        oscillator_kept;
   logic        next_oscillator_kept;

   always_comb begin
      next_state = state;
      next_count = count;
      next_oscillator_kept = oscillator_kept;
      // Heavier sources pre-empt lighter ones at any point
      if (pwr_low) begin
         next_state = rst_seq_pkg::ST_HOLD_EXT;
         next_oscillator_kept = 1'b0;
      end else if (pin_reset) begin
         next_state = rst_seq_pkg::ST_HOLD_EXT;
         next_oscillator_kept = 1'b0;
      end else if (wd2_event && mode_ctrl[`FLD_WD2_EN]) begin
         next_state = rst_seq_pkg::ST_HOLD_WD2;
         next_count = 17'h0_0000;
         next_oscillator_kept = 1'b0;
      end else if (wd1_event && mode_ctrl[`FLD_WD1_EN] &&
                   (state == rst_seq_pkg::ST_RUN || state == rst_seq_pkg::ST_HOLD_WD1)) begin
         next_state = rst_seq_pkg::ST_HOLD_WD1;
         next_count = 17'h0_0000;
         next_oscillator_kept = 1'b1;
      end else begin
         case (state)
            rst_seq_pkg::ST_RUN: begin
               next_count = 17'h0_0000;
            end
            rst_seq_pkg::ST_HOLD_WD1: begin
               if (count == 17'(`WD1_HOLD_CYCLES - 1)) begin
                  next_state = rst_seq_pkg::ST_RUN;
               end else begin
                  next_count = count + 17'h0_0001;
               end
            end
            rst_seq_pkg::ST_HOLD_WD2: begin
               if (count == 17'(WD2_CYCLES - 1)) begin
                  next_state = rst_seq_pkg::ST_STAB;
                  next_count = 17'h0_0000;
               end else begin
                  next_count = count + 17'h0_0001;
               end
            end
            rst_seq_pkg::ST_HOLD_EXT: begin
               next_state = rst_seq_pkg::ST_STAB;
               next_count = 17'h0_0000;
            end
            rst_seq_pkg::ST_STAB: begin
               if (count == 17'(STAB_CYCLES - 1)) begin
                  next_state = rst_seq_pkg::ST_RUN;
               end else begin
                  next_count = count + 17'h0_0001;
               end
            end
            default: next_state = rst_seq_pkg::ST_HOLD_EXT;
         endcase
      end
      next_soft_reset = (next_state == rst_seq_pkg::ST_HOLD_WD1) ||
                        (next_state == rst_seq_pkg::ST_HOLD_WD2) ||
                        (next_state == rst_seq_pkg::ST_HOLD_EXT);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= rst_seq_pkg::ST_HOLD_EXT;
         count <= 17'h0_0000;
         soft_reset <= 1'b1;
         oscillator_kept <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         soft_reset <= next_soft_reset;
         oscillator_kept <= next_oscillator_kept;
      end
   end

   // Clock and port controls registered from the next state; RAM flag from the registered reset
   logic next_main_osc;
   logic next_int_osc;
   logic next_periph;
   logic next_sys_clk;
   logic next_wd1_clk;
   logic next_wd2_run;
   logic next_cpu_run;
   logic next_ram_corrupt;
   rst_seq_pkg::clk_mode_e clk_mode;

   assign main_running = main_osc_enable;

   always_comb begin
      next_main_osc = 1'b1;
      next_int_osc = 1'b1;
      next_periph = 1'b0;
      next_sys_clk = 1'b0;
      next_wd1_clk = 1'b1;
      next_wd2_run = 1'b0;
      next_cpu_run = 1'b0;
      clk_mode = rst_seq_pkg::CLK_DIV8;
      case (next_state)
         rst_seq_pkg::ST_HOLD_WD1: begin
            next_sys_clk = 1'b1;
         end
         rst_seq_pkg::ST_HOLD_WD2,
         rst_seq_pkg::ST_HOLD_EXT: begin
            next_main_osc = 1'b0;
            next_int_osc = 1'b0;
            next_wd1_clk = 1'b0;
            clk_mode = rst_seq_pkg::CLK_OFF;
         end
         rst_seq_pkg::ST_STAB: begin
            next_wd2_run = 1'b1;
         end
         rst_seq_pkg::ST_RUN: begin
            next_periph = 1'b1;
            next_sys_clk = 1'b1;
            next_wd2_run = 1'b1;
            next_cpu_run = 1'b1;
            clk_mode = rst_seq_pkg::CLK_RUN;
         end
         default: clk_mode = rst_seq_pkg::CLK_OFF;
      endcase
      next_ram_corrupt = soft_reset & cpu_ram_write;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_osc_enable <= 1'b0;
         internal_osc_enable <= 1'b0;
         peripheral_clock_enable <= 1'b0;
         system_clock_enable <= 1'b0;
         system_clock_div8 <= 1'b1;
         watchdog_one_clock_enable <= 1'b0;
         watchdog_two_run <= 1'b0;
         cpu_run <= 1'b0;
         system_reset <= 1'b1;
         ram_write_corrupt <= 1'b0;
         reset_out_port_line_o <= 1'b0;
         reset_out_port_line_oe <= 1'b1;
         subclock_enable <= 1'b1;
         ports_release <= 1'b0;
      end else begin
         main_osc_enable <= next_main_osc;
         internal_osc_enable <= next_int_osc;
         peripheral_clock_enable <= next_periph;
         system_clock_enable <= next_sys_clk;
         // Clock divider is set to div8 on every reset and stays set; nothing clears it later
         system_clock_div8 <= (clk_mode != rst_seq_pkg::CLK_RUN) | system_clock_div8;
         watchdog_one_clock_enable <= next_wd1_clk;
         watchdog_two_run <= next_wd2_run;
         cpu_run <= next_cpu_run;
         system_reset <= next_soft_reset;
         ram_write_corrupt <= next_ram_corrupt;
         reset_out_port_line_o <= 1'b0;
         reset_out_port_line_oe <= next_soft_reset | reset_out_port_line_oe;
         ports_release <= ~next_soft_reset;
         subclock_enable <= 1'b1;
      end
   end

endmodule : reset_source_sequencer
`default_nettype wire

/* tb/rst_seq_sva.sv */
// Concurrent checks on the reset sequencer outputs
`default_nettype none
module rst_seq_sva #(
   parameter int STAB_CYCLES = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cpu_ram_write,
   input wire logic system_reset,
   input wire logic cpu_run,
   input wire logic main_osc_enable,
   input wire logic internal_osc_enable,
   input wire logic subclock_enable,
   input wire logic peripheral_clock_enable,
   input wire logic system_clock_enable,
   input wire logic system_clock_div8,
   input wire logic watchdog_one_clock_enable,
   input wire logic watchdog_two_run,
   input wire logic reset_out_port_line_o,
   input wire logic reset_out_port_line_oe,
   input wire logic ports_release,
   input wire logic ram_write_corrupt
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STAB_LO = STAB_CYCLES - 1;
   localparam int STAB_HI = STAB_CYCLES + 1;
   logic [7:0] hold_cnt;
   logic [7:0] next_hold_cnt;
   logic [7:0] stab_cnt;
   logic [7:0] next_stab_cnt;
   // Saturate so a long supply dip cannot wrap into a false match
   always_comb begin
      next_hold_cnt = system_reset ? hold_cnt + {7'h00, hold_cnt != 8'hFF} : 8'h00;
      next_stab_cnt = (!system_reset && !cpu_run) ? stab_cnt + {7'h00, stab_cnt != 8'hFF} : 8'h00;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt <= 8'h00;
         stab_cnt <= 8'h00;
      end else begin
         hold_cnt <= next_hold_cnt;
         stab_cnt <= next_stab_cnt;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Oscillator kept running marks the short watchdog-one release
   sequence s_fast_release;
      $fell(system_reset) && $past(main_osc_enable);
   endsequence
   sequence s_slow_release;
      $fell(system_reset) && !$past(main_osc_enable);
   endsequence
   chk_wd1_hold: assert property (s_fast_release |-> hold_cnt == 8'h0C)
      else $error("watchdog one hold not 12 cycles");
   chk_wd1_nowait: assert property (s_fast_release |-> ##[0:1] cpu_run)
      else $error("stabilisation wait after watchdog one reset");
   chk_slow_wait: assert property (s_slow_release |->
      (!cpu_run && !system_clock_enable && !peripheral_clock_enable
      && watchdog_one_clock_enable)[*8])
      else $error("clocks wrong during stabilisation wait");
   chk_stab_len: assert property ($rose(cpu_run) |-> stab_cnt <= 8'h01
      || (stab_cnt >= STAB_LO && stab_cnt <= STAB_HI))
      else $error("stabilisation wait length wrong");
   chk_port_hold: assert property (system_reset |-> reset_out_port_line_oe
      && !reset_out_port_line_o && !ports_release)
      else $error("port lines wrong during reset");
   chk_wd2_stop: assert property (system_reset |-> !watchdog_two_run)
      else $error("watchdog two runs during reset");
   chk_wd2_start: assert property ($fell(system_reset) |-> ##[0:1] watchdog_two_run)
      else $error("watchdog two not started after reset");
   chk_wd1_clocks: assert property (system_reset && main_osc_enable |->
      internal_osc_enable && system_clock_enable && watchdog_one_clock_enable
      && !peripheral_clock_enable && system_clock_div8)
      else $error("clock states wrong in watchdog one reset");
   chk_osc_stop: assert property (system_reset && !main_osc_enable |->
      !internal_osc_enable && !system_clock_enable && !watchdog_one_clock_enable
      && subclock_enable)
      else $error("oscillators not stopped in long reset");
   chk_ram_flag: assert property (system_reset && cpu_ram_write |->
      ##[0:1] ram_write_corrupt)
      else $error("colliding RAM write not flagged");
   chk_div8_run: assert property ($rose(cpu_run) |-> system_clock_div8)
      else $error("CPU restarted without divide by eight");
endmodule : rst_seq_sva
bind reset_source_sequencer rst_seq_sva #(.STAB_CYCLES(STAB_CYCLES)) u_sva (
   .clk, .rst_n, .cpu_ram_write, .system_reset, .cpu_run, .main_osc_enable,
   .internal_osc_enable, .subclock_enable, .peripheral_clock_enable, .system_clock_enable,
   .system_clock_div8, .watchdog_one_clock_enable, .watchdog_two_run, .reset_out_port_line_o,
   .reset_out_port_line_oe, .ports_release, .ram_write_corrupt
);
`default_nettype wire

/* tb/rst_far_side.sv */
// Model of the watchdogs, supply detector and reset pin around the sequencer
`default_nettype none
module rst_far_side (
   input  wire logic clk,
   output var logic  reset_pin_n,
   output var logic  watchdog_one_overflow,
   output var logic  watchdog_two_overflow,
   output var logic  supply_below_threshold,
   output var logic  sample_clock_stopped
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pin has a pull-up, so it idles high
   initial begin
      reset_pin_n = 1'b1;
      watchdog_one_overflow = 1'b0;
      watchdog_two_overflow = 1'b0;
      supply_below_threshold = 1'b0;
      sample_clock_stopped = 1'b0;
   end
   // Held three cycles so the overflow survives the input synchroniser
   task wd_pulse(input logic two);
      @(posedge clk);
      watchdog_one_overflow <= !two;
      watchdog_two_overflow <= two;
      repeat (3) @(posedge clk);
      watchdog_one_overflow <= 1'b0;
      watchdog_two_overflow <= 1'b0;
   endtask : wd_pulse
   task pin_pulse(input int n);
      @(posedge clk);
      reset_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      reset_pin_n <= 1'b1;
   endtask : pin_pulse
   task supply_level(input logic low);
      @(posedge clk);
      supply_below_threshold <= low;
   endtask : supply_level
   task sampling_stop(input logic s);
      @(posedge clk);
      sample_clock_stopped <= s;
   endtask : sampling_stop
endmodule : rst_far_side
`default_nettype wire

/* tb/reset_source_sequencer_tb_top.sv */
// Self-checking bench for the reset sequencer
`include "rst_seq_cfg.svh"
`default_nettype none
module reset_source_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STAB = 16;
   logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_ram_write;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [3:0] wb_sel_i;
   logic system_reset, cpu_run, main_osc_enable, internal_osc_enable, subclock_enable;
   logic peripheral_clock_enable, system_clock_enable, system_clock_div8;
   logic watchdog_one_clock_enable, watchdog_two_run, reset_out_port_line_o;
   logic reset_out_port_line_oe, ports_release, ram_write_corrupt;
   logic reset_pin_n, watchdog_one_overflow, watchdog_two_overflow;
   logic supply_below_threshold, sample_clock_stopped;
   int err_total, n_tests, holds, last_hold, cur_hold, h, n;
   reset_source_sequencer #(.STAB_CYCLES(STAB)) uut (
      .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_dat_o, .wb_ack_o, .reset_pin_n, .watchdog_one_overflow, .watchdog_two_overflow,
      .supply_below_threshold, .sample_clock_stopped, .cpu_ram_write, .system_reset,
      .cpu_run, .main_osc_enable, .internal_osc_enable, .subclock_enable,
      .peripheral_clock_enable, .system_clock_enable, .system_clock_div8,
      .watchdog_one_clock_enable, .watchdog_two_run, .reset_out_port_line_o,
      .reset_out_port_line_oe, .ports_release, .ram_write_corrupt
   );
   rst_far_side far (
      .clk, .reset_pin_n, .watchdog_one_overflow, .watchdog_two_overflow,
      .supply_below_threshold, .sample_clock_stopped
   );
   always #25 clk = ~clk;
   // Length of the last finished reset hold and how many holds were seen
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_hold <= 0;
      end else if (system_reset) begin
         cur_hold <= cur_hold + 1;
      end else if (cur_hold != 0) begin
         last_hold <= cur_hold;
         holds <= holds + 1;
         cur_hold <= 0;
      end
   end
   task results;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (i >= 50) begin
         err_total++;
         results;
      end
   endtask : wb
   task wait_run;
      int i;
      i = 0;
      while (cpu_run === 1'b1 && i < 20) begin
         @(posedge clk);
         i++;
      end
      i = 0;
      while (cpu_run !== 1'b1 && i < 400) begin
         @(posedge clk);
         i++;
      end
      // One more edge so the hold counter has taken a release that coincides with restart
      @(posedge clk);
      if (i >= 400) begin
         err_total++;
         results;
      end
   endtask : wait_run
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, cpu_ram_write} = 4'h0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'hF;
      {err_total, n_tests} = '0;
      // Both sample counts need a fresh reset, since the filter setting locks
      for (int s = 0; s < 2; s++) begin
         rst_n <= 1'b0;
         repeat (3) @(posedge clk);
         rst_n <= 1'b1;
         wait_run;
         wb(1'b0, `OFS_FILTER_CTRL, 32'h0);
         chk(rd, {24'h0, `FILTER_CTRL_RST});
         wb(1'b0, `OFS_MODE_CTRL, 32'h0);
         chk(rd, {24'h0, `MODE_CTRL_RST});
         wb(1'b0, 8'h10, 32'h0);
         chk(rd, 32'h0);
         wb(1'b1, `OFS_FILTER_CTRL, 32'h2 | s);
         wb(1'b1, `OFS_FILTER_CTRL, 32'h0);
         wb(1'b0, `OFS_FILTER_CTRL, 32'h0);
         chk(rd, 32'h6 | s);
         n = s ? `SAMPLES_SHORT : `SAMPLES_LONG;
         h = holds;
         far.pin_pulse(n - 2);
         repeat (20) @(posedge clk);
         chk(holds, h);
         far.pin_pulse(n + 1);
         wait_run;
         chk(holds, h + 1);
      end
      far.sampling_stop(1'b1);
      h = holds;
      far.pin_pulse(3);
      wait_run;
      chk(holds, h + 1);
      far.sampling_stop(1'b0);
      for (int w = 0; w < 2; w++) begin
         wb(1'b1, `OFS_CAUSE, 32'h7);
         h = holds;
         far.wd_pulse(w);
         wait_run;
         chk(holds, h + 1);
         chk(last_hold, w ? `WD2_DELAY_CYCLES : `WD1_HOLD_CYCLES);
         wb(1'b0, `OFS_CAUSE, 32'h0);
         chk(rd, w ? 32'h4 : 32'h2);
         wb(1'b1, `OFS_MODE_CTRL, w ? 32'h1 : 32'h2);
         h = holds;
         far.wd_pulse(w);
         repeat (20) @(posedge clk);
         chk(holds, h);
         wb(1'b1, `OFS_MODE_CTRL, 32'h3);
      end
      far.supply_level(1'b1);
      repeat (10) @(posedge clk);
      cpu_ram_write <= 1'b1;
      @(posedge clk);
      cpu_ram_write <= 1'b0;
      chk({30'h0, system_reset, main_osc_enable}, 32'h2);
      @(posedge clk);
      chk({31'h0, ram_write_corrupt}, 32'h1);
      repeat (30) @(posedge clk);
      far.supply_level(1'b0);
      wait_run;
      chk(last_hold >= 35, 32'h1);
      results;
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      results;
   end
endmodule : reset_source_sequencer_tb_top
`default_nettype wire
